/* core/crtt_raster.sv */
// Raster timing, line counter and row format logic with an APB register slave
// Behaviour
// - Line address holds during a sweep, advances in horizontal retrace, row repeats.
// - Lines per character row are programmable from one to sixteen.
// - Mode zero puts the line number itself on the line address.
// - Mode one lags by one; line zero shows the row's last count.
// - Underline line is 0 to 15, compared against the line number.
// - Underline line above seven blanks the top and bottom lines of rows.
// - Underline beyond the lines per row never appears.
// - Blanking uses video suppress; underline uses light enable.
// - Character counter counts 1 to 80 characters, then 2 to 32 retrace.
// - Line counter drives line address and advances the row counter at wrap.
// - Row counter counts 1 to 64 rows, then 1 to 4 retrace rows.
// - Row counter swaps the row buffers and tracks rows displayed.
// - Video suppress is active through all horizontal and vertical retrace.
// - Horizontal and vertical retrace outputs follow the programmed intervals.
`timescale 1ns/100ps
`default_nettype none

module crtt_raster (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic char_clock_in,
  output logic [3:0] line_address_out,
  output logic video_suppress_out,
  output logic light_enable_out,
  output logic horiz_retrace_out,
  output logic vert_retrace_out,
  output logic buffer_select_out
);
  import crtt_pkg::*;

  // ****************************************************************
  // Reset and character clock synchronisers
  // ****************************************************************
  logic rst_meta;
  logic rst_n;
  logic char_clock_in_meta;
  logic char_clock_in_sync;
  logic char_clock_in_last;
  logic tick;

  // Reset asserts at once and releases through two flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Character clock is a pin; the first flop feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      char_clock_in_meta <= 1'b0;
      char_clock_in_sync <= 1'b0;
      char_clock_in_last <= 1'b0;
    end else begin
      char_clock_in_meta <= char_clock_in;
      char_clock_in_sync <= char_clock_in_meta;
      char_clock_in_last <= char_clock_in_sync;
    end
  end

  // One character time per rising edge of the character clock
  assign tick = char_clock_in_sync & ~char_clock_in_last;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [31:0] fmt0;
  logic [31:0] fmt1;
  crtt_cfg_t cfg;
  logic acc_wr;
  logic addr_hit;
  logic [31:0] next_prdata;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign acc_wr = psel & penable & pwrite;
  assign addr_hit = (paddr == CRTT_REG_FMT0) || (paddr == CRTT_REG_FMT1) || (paddr == CRTT_REG_STAT);
  assign pslverr = psel & penable & ~addr_hit;

  // Format words; status is read only and a write to it is ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt0 <= CRTT_FMT0_RST;
      fmt1 <= CRTT_FMT1_RST;
    end else if (acc_wr) begin
      if (paddr == CRTT_REG_FMT0) begin
        fmt0 <= pwdata;
      end
      if (paddr == CRTT_REG_FMT1) begin
        fmt1 <= pwdata;
      end
    end
  end

  // Unpack format; out-of-range counts are clamped so the raster never stalls
  always_comb begin
    cfg.chars_m1 = fmt0[CRTT_F0_CHARS_LSB +: 7];
    if (cfg.chars_m1 > CRTT_CHARS_MAX_M1) begin
      cfg.chars_m1 = CRTT_CHARS_MAX_M1;
    end
    cfg.hret_m1 = fmt0[CRTT_F0_HRET_LSB +: 5];
    if (cfg.hret_m1 < CRTT_HRET_MIN_M1) begin
      cfg.hret_m1 = CRTT_HRET_MIN_M1;
    end
    cfg.lines_m1 = fmt1[CRTT_F1_LINES_LSB +: 4];
    cfg.underline = fmt1[CRTT_F1_UL_LSB +: 4];
    cfg.mode1 = fmt1[CRTT_F1_MODE_BIT];
    cfg.rows_m1 = fmt1[CRTT_F1_ROWS_LSB +: 6];
    cfg.vret_m1 = fmt1[CRTT_F1_VRET_LSB +: 2];
    cfg.enable = fmt1[CRTT_F1_EN_BIT];
  end

  // ****************************************************************
  // Character counter
  // ****************************************************************
  crtt_hphase_t hphase;
  logic [6:0] char_cnt;
  logic line_end;

  // Last character of the displayed part of a sweep
  assign line_end = tick && (hphase == CRTT_H_DISP) && (char_cnt == cfg.chars_m1);

  // Displayed characters, then retrace, forever while enabled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hphase <= CRTT_H_DISP;
      char_cnt <= 7'h00;
    end else if (!cfg.enable) begin
      hphase <= CRTT_H_DISP;
      char_cnt <= 7'h00;
    end else if (tick) begin
      case (hphase)
        CRTT_H_DISP: begin
          if (line_end) begin
            hphase <= CRTT_H_RET;
            char_cnt <= 7'h00;
          end else begin
            char_cnt <= char_cnt + 7'h01;
          end
        end
        CRTT_H_RET: begin
          if (char_cnt[4:0] == cfg.hret_m1) begin
            hphase <= CRTT_H_DISP;
            char_cnt <= 7'h00;
          end else begin
            char_cnt <= char_cnt + 7'h01;
          end
        end
        default: begin
          hphase <= CRTT_H_DISP;
          char_cnt <= 7'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Line counter
  // ****************************************************************
  logic [3:0] line_num;
  logic row_end;

  // Last line of a character row reached at the end of its sweep
  assign row_end = line_end && (line_num == cfg.lines_m1);

  // Holds through the sweep and steps as horizontal retrace begins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_num <= 4'h0;
    end else if (!cfg.enable) begin
      line_num <= 4'h0;
    end else if (row_end) begin
      line_num <= 4'h0;
    end else if (line_end) begin
      line_num <= line_num + 4'h1;
    end
  end

  // ****************************************************************
  // Row counter and buffer steering
  // ****************************************************************
  crtt_vphase_t vphase;
  logic [5:0] row_cnt;
  logic buf_sel;

  // Displayed rows, then vertical retrace in whole row periods
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vphase <= CRTT_V_ROWS;
      row_cnt <= 6'h00;
    end else if (!cfg.enable) begin
      vphase <= CRTT_V_ROWS;
      row_cnt <= 6'h00;
    end else if (row_end) begin
      case (vphase)
        CRTT_V_ROWS: begin
          if (row_cnt == cfg.rows_m1) begin
            vphase <= CRTT_V_RET;
            row_cnt <= 6'h00;
          end else begin
            row_cnt <= row_cnt + 6'h01;
          end
        end
        CRTT_V_RET: begin
          if (row_cnt[1:0] == cfg.vret_m1) begin
            vphase <= CRTT_V_ROWS;
            row_cnt <= 6'h00;
          end else begin
            row_cnt <= row_cnt + 6'h01;
          end
        end
        default: begin
          vphase <= CRTT_V_ROWS;
          row_cnt <= 6'h00;
        end
      endcase
    end
  end

  // Display and fill buffers swap roles at each displayed row boundary
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_sel <= 1'b0;
    end else if (row_end && (vphase == CRTT_V_ROWS)) begin
      buf_sel <= ~buf_sel;
    end
  end

  // ****************************************************************
  // Video controls
  // ****************************************************************
  logic [3:0] next_line_addr;
  logic ul_hit;
  logic edge_blank;
  logic in_hret;
  logic in_vret;

  assign in_hret = cfg.enable && (hphase == CRTT_H_RET);
  assign in_vret = cfg.enable && (vphase == CRTT_V_RET);

  // Line address in either mode; mode one wraps line zero to the last count
  always_comb begin
    if (!cfg.mode1) begin
      next_line_addr = line_num;
    end else if (line_num == 4'h0) begin
      next_line_addr = cfg.lines_m1;
    end else begin
      next_line_addr = line_num - 4'h1;
    end
  end

  // Underline compares the line number; never past the last line of the row
  assign ul_hit = (line_num == cfg.underline) && (cfg.underline <= cfg.lines_m1);
  // Underline in the upper half blanks the first and last line of each row
  assign edge_blank = cfg.underline[3] && ((line_num == 4'h0) || (line_num == cfg.lines_m1));

  // Outputs come from flops, one reference clock behind the counters
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_address_out <= 4'h0;
      video_suppress_out <= 1'b1;
      light_enable_out <= 1'b0;
      horiz_retrace_out <= 1'b0;
      vert_retrace_out <= 1'b0;
      buffer_select_out <= 1'b0;
    end else begin
      line_address_out <= next_line_addr;
      video_suppress_out <= !cfg.enable || in_hret || in_vret || edge_blank;
      light_enable_out <= cfg.enable && !in_hret && !in_vret && ul_hit;
      horiz_retrace_out <= in_hret;
      vert_retrace_out <= in_vret;
      buffer_select_out <= buf_sel;
    end
  end

  // ****************************************************************
  // Register read-back
  // ****************************************************************
  // Status shows live counter state so software can follow the raster
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      case (paddr)
        CRTT_REG_FMT0: next_prdata = fmt0;
        CRTT_REG_FMT1: next_prdata = fmt1;
        CRTT_REG_STAT: begin
          next_prdata[CRTT_ST_LINE_LSB +: 4] = line_num;
          next_prdata[CRTT_ST_ROW_LSB +: 6] = row_cnt;
          next_prdata[CRTT_ST_CHAR_LSB +: 7] = char_cnt;
          next_prdata[CRTT_ST_HRET_BIT] = in_hret;
          next_prdata[CRTT_ST_VRET_BIT] = in_vret;
          next_prdata[CRTT_ST_BUF_BIT] = buf_sel;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Setup cycle loads the flop, so the access cycle still answers with no wait state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Last character of the last line of a row
  sequence s_row_wrap;
    row_end && (vphase == CRTT_V_ROWS) && cfg.enable;
  endsequence

  // Retrace output follows the last character of the sweep by two reference clocks
  sequence s_sweep_done;
    line_end && cfg.enable;
  endsequence
  a_line_steps_in_ret: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(line_num) && cfg.enable && $stable(cfg.enable) |-> hphase == CRTT_H_RET)
    else $error("line number changed outside horizontal retrace");
  a_mode0_address: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cfg.mode1 && $stable(fmt1) |=> line_address_out == $past(line_num))
    else $error("mode zero line address differs from line number");
  a_mode1_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.mode1 && line_num == 4'h0 && $stable(fmt1) |=> line_address_out == $past(cfg.lines_m1))
    else $error("mode one line zero does not show last count");
  a_edge_blanking: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.underline[3] && line_num == 4'h0 |=> video_suppress_out)
    else $error("top line not blanked with upper underline");
  a_no_underline: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.underline > cfg.lines_m1 && $stable(fmt1) |=> !light_enable_out)
    else $error("underline shown beyond last line");
  a_char_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hphase == CRTT_H_DISP |-> char_cnt <= CRTT_CHARS_MAX_M1)
    else $error("character count beyond eighty");
  a_row_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_row_wrap ##0 (row_cnt != cfg.rows_m1) |=> row_cnt == $past(row_cnt) + 6'h01 && line_num == 4'h0)
    else $error("row counter did not advance at end of row");
  a_buffer_swap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_row_wrap |=> ##1 buffer_select_out != $past(buffer_select_out))
    else $error("row buffers not swapped at row boundary");
  a_hret_suppress: assert property (@(posedge ref_clk) disable iff (!rst_n)
    horiz_retrace_out || vert_retrace_out |-> video_suppress_out)
    else $error("video not suppressed during retrace");
  a_hret_timing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_sweep_done ##1 cfg.enable |=> horiz_retrace_out [*2])
    else $error("horizontal retrace output late or short");
endmodule : crtt_raster

`default_nettype wire

/* core/crtt_pkg.sv */
// Package of constants and types for the CRT raster row and line timing block
package crtt_pkg;

  // ****************************************************************
  // Register map, byte offsets on the APB
  // ****************************************************************
  localparam logic [7:0] CRTT_REG_FMT0 = 8'h00;
  localparam logic [7:0] CRTT_REG_FMT1 = 8'h04;
  localparam logic [7:0] CRTT_REG_STAT = 8'h08;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  // Format word 0: characters per row minus one, retrace length minus one
  localparam int CRTT_F0_CHARS_LSB = 0;
  localparam int CRTT_F0_HRET_LSB = 8;
  // Format word 1: lines, underline, mode, rows, vertical retrace, enable
  localparam int CRTT_F1_LINES_LSB = 0;
  localparam int CRTT_F1_UL_LSB = 4;
  localparam int CRTT_F1_MODE_BIT = 8;
  localparam int CRTT_F1_ROWS_LSB = 16;
  localparam int CRTT_F1_VRET_LSB = 24;
  localparam int CRTT_F1_EN_BIT = 31;
  // Status word
  localparam int CRTT_ST_LINE_LSB = 0;
  localparam int CRTT_ST_ROW_LSB = 8;
  localparam int CRTT_ST_CHAR_LSB = 16;
  localparam int CRTT_ST_HRET_BIT = 24;
  localparam int CRTT_ST_VRET_BIT = 25;
  localparam int CRTT_ST_BUF_BIT = 26;

  // ****************************************************************
  // Reset values and limits
  // ****************************************************************
  localparam logic [31:0] CRTT_FMT0_RST = 32'h0000_134F;  // 80 chars, 20 retrace
  localparam logic [31:0] CRTT_FMT1_RST = 32'h0118_00B9;  // 10 lines, ul 11, 25 rows, 2 vret
  localparam logic [6:0] CRTT_CHARS_MAX_M1 = 7'h4F;      // 80 characters
  localparam logic [4:0] CRTT_HRET_MIN_M1 = 5'h01;       // 2 character times

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic [1:0] vret_m1;
    logic [5:0] rows_m1;
    logic mode1;
    logic [3:0] underline;
    logic [3:0] lines_m1;
    logic [4:0] hret_m1;
    logic [6:0] chars_m1;
  } crtt_cfg_t;

  typedef enum logic [1:0] {
    CRTT_H_DISP = 2'b01,
    CRTT_H_RET = 2'b10
  } crtt_hphase_t;

  typedef enum logic [1:0] {
    CRTT_V_ROWS = 2'b01,
    CRTT_V_RET = 2'b10
  } crtt_vphase_t;

endpackage : crtt_pkg

/* tb/crtt_dot_model.sv */
// Behavioural model of the external dot-level timing that makes the character clock
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Character clock source and video re-timing
// ****************************************************************
module crtt_dot_model (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [4:0] half,
  input wire logic [3:0] line_address_out,
  output logic char_clock_in,
  output logic pre_edge
);
  logic [4:0] cnt = 5'h00;
  logic [3:0] rom_addr = 4'h0;
  logic [7:0] shifter = 8'h00;
  logic char_clock_in_q = 1'b0;

  // Clock stands still low between frames; a started period is always finished
  assign char_clock_in = char_clock_in_q;
  always @(posedge ref_clk) begin
    cnt <= (cnt == half - 5'h01) ? 5'h00 : cnt + 5'h01;
    if (cnt == half - 5'h01 && (char_clock_in_q || run)) begin
      char_clock_in_q <= ~char_clock_in_q;
    end
  end

  // High in the last cycle before a rising character edge
  assign pre_edge = run && !char_clock_in_q && cnt == half - 5'h01;

  // Latch at the character boundary to hide the generator access delay
  always @(posedge ref_clk) begin
    if (pre_edge) begin
      rom_addr <= line_address_out;
      shifter <= {rom_addr, ~rom_addr};
    end else begin
      shifter <= {shifter[6:0], 1'b0};
    end
  end
endmodule : crtt_dot_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the raster timing block with a behavioural reference
`timescale 1ns/100ps
`default_nettype none

module tb;
  import crtt_pkg::*;
  logic ref_clk, resetn, psel, penable, pwrite, run, er, pbuf, checking;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, f0, f1;
  logic pready, pslverr, char_clock_in, pre_edge, buffer_select_out;
  logic video_suppress_out, light_enable_out, horiz_retrace_out, vert_retrace_out;
  logic [3:0] line_address_out;
  logic [4:0] half;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int c, ln, r, hp, vp, bt, frame;
  crtt_cfg_t cfg, k;
  // Boundary formats: 16 lines, 10 lines with unreachable underline, 1 line, 8 lines, 80 chars
  crtt_cfg_t fixed_cfg [5] = '{'{1'b0, 2'd0, 6'd1, 1'b1, 4'hF, 4'hF, 5'd1, 7'd0},
    '{1'b0, 2'd3, 6'd0, 1'b1, 4'hB, 4'h9, 5'd2, 7'd3}, '{1'b0, 2'd1, 6'd2, 1'b0, 4'h0, 4'h0, 5'd1, 7'd2},
    '{1'b0, 2'd0, 6'd3, 1'b0, 4'h7, 4'h7, 5'd3, 7'd1}, '{1'b0, 2'd0, 6'd0, 1'b0, 4'h8, 4'h0, 5'd31, 7'd79}};

  crtt_raster crtt_raster_inst (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .char_clock_in, .line_address_out, .video_suppress_out, .light_enable_out,
    .horiz_retrace_out, .vert_retrace_out, .buffer_select_out);
  crtt_dot_model crtt_dot_model_inst (.ref_clk, .run, .half, .line_address_out, .char_clock_in, .pre_edge);

  // ****************************************************************
  // Clock, timeout and reporting
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_sim();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Cut a hang short well above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      end_sim();
    end
  end

  // ****************************************************************
  // APB master and reference model
  // ****************************************************************
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Row boundary: bt says whether the buffer toggles (1), holds (0) or is not judged (-1)
  task row_step();
    if (!vp && r == cfg.rows_m1) begin
      vp = 1;
      r = 0;
      bt = 1;
    end else if (!vp) begin
      r++;
      bt = 1;
    end else if (r == cfg.vret_m1) begin
      vp = 0;
      r = 0;
    end else begin
      r++;
    end
  endtask : row_step

  // One character time of the reference counters
  task step();
    bt = 0;
    if (!hp && c == cfg.chars_m1) begin
      hp = 1;
      c = 0;
      ln = (ln == cfg.lines_m1) ? 0 : ln + 1;
      if (ln == 0) row_step();
    end else if (!hp || c != cfg.hret_m1) begin
      c++;
    end else begin
      hp = 0;
      c = 0;
    end
  endtask : step

  // Outputs are settled just before each rising character edge
  always @(posedge ref_clk) begin
    if (checking && pre_edge) begin
      chk(horiz_retrace_out, hp[0]);
      chk(vert_retrace_out, vp[0]);
      chk(line_address_out, cfg.mode1 ? (ln == 0 ? cfg.lines_m1 : ln - 1) : ln);
      chk(video_suppress_out, hp || vp || (cfg.underline > 7 && (ln == 0 || ln == cfg.lines_m1)));
      chk(light_enable_out, ln == cfg.underline && cfg.underline <= cfg.lines_m1 && !hp && !vp);
      if (bt >= 0) chk(buffer_select_out, pbuf ^ bt[0]);
      pbuf = buffer_select_out;
      step();
    end
  end

  // Program a format, run one frame plus 20 character times (600 if the frame is over 600), then disable
  task run_cfg(input crtt_cfg_t kk, input logic [4:0] hh);
    cfg = kk;
    f0 = {19'h0, cfg.hret_m1, 1'b0, cfg.chars_m1};
    f1 = {1'b1, 5'h0, cfg.vret_m1, 2'h0, cfg.rows_m1, 7'h0, cfg.mode1, cfg.underline, cfg.lines_m1};
    apb(1'b1, CRTT_REG_FMT0, f0);
    apb(1'b1, CRTT_REG_FMT1, f1);
    apb(1'b0, CRTT_REG_FMT0, 32'h0);
    chk(rd, f0);
    apb(1'b0, CRTT_REG_FMT1, 32'h0);
    chk(rd, f1);
    frame = (cfg.rows_m1 + cfg.vret_m1 + 2) * (cfg.lines_m1 + 1) * (cfg.chars_m1 + cfg.hret_m1 + 2);
    {c, ln, r, hp, vp, bt} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0, -32'sd1};
    half <= hh;
    checking = 1'b1;
    run <= 1'b1;
    repeat (frame > 600 ? 600 : frame + 20) begin
      @(posedge ref_clk);
      while (pre_edge !== 1'b1) @(posedge ref_clk);
    end
    run <= 1'b0;
    repeat (24) @(posedge ref_clk);
    checking = 1'b0;
    apb(1'b1, CRTT_REG_FMT1, f1 & 32'h7FFF_FFFF);
    repeat (3) @(posedge ref_clk);
    // Disabled block parks on line zero, which mode one shows as the last count
    chk({video_suppress_out, light_enable_out, horiz_retrace_out, line_address_out}, {3'b100, (cfg.mode1 ? cfg.lines_m1 : 4'h0)});
  endtask : run_cfg

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rd = $urandom(32'h0413);
    {resetn, psel, penable, pwrite, run, checking} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    half = 5'd5;
    repeat (10) @(posedge ref_clk);
    chk({video_suppress_out, light_enable_out, vert_retrace_out, buffer_select_out}, 4'h8);
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, CRTT_REG_FMT0, 32'h0);
    chk(rd, CRTT_FMT0_RST);
    apb(1'b0, CRTT_REG_FMT1, 32'h0);
    chk(rd, CRTT_FMT1_RST);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    chk(er, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, CRTT_REG_STAT, 32'hFFFF_FFFF);
    apb(1'b0, CRTT_REG_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, CRTT_REG_FMT0, 32'h0);
    chk(rd, CRTT_FMT0_RST);
    for (int i = 0; i < 5; i++) begin
      run_cfg(fixed_cfg[i], (i == 3) ? 5'd9 : 5'd5);
    end
    // Random small formats keep each frame within 1344 character times; a run stops at 600
    for (int i = 0; i < 5; i++) begin
      k = crtt_cfg_t'($urandom);
      k.chars_m1 = k.chars_m1 % 8;
      k.hret_m1 = 5'd1 + k.hret_m1 % 3;
      k.rows_m1 = k.rows_m1 % 3;
      run_cfg(k, 5'd5);
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire
